// ===== bench/ord_core_bench.sv
// Purpose: Self-checking bench of the rename/dispatch core
// Assumes: Inputs move 1 ns after each rising edge of REF_CLK
// Notes: Completion is internal, so progress is judged by DISP counts
module ord_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef ord_pkg::ord_slot_t [3:0] ord_grp_t;
   logic REF_CLK = 1'b0, RESET = 1'b1, EXEC_FAULT = 1'b0, UQ_VALID, UQ_READY, FAULT;
   logic [7:0] EXEC_FAULT_TAG = 8'h00, FAULT_TAG, tag;
   ord_grp_t UQ_SLOT;
   ord_pkg::ord_disp_t [5:0] DISP;
   logic [3:0] ZERO_WR;
   logic [3:0][4:0] ZERO_REG;
   logic [2:0] RETIRE_CNT;
   logic [31:0] zmask = 32'h0;
   int fails = 0, checks_done = 0, ndisp = 0, ncls[32];
   always #20 REF_CLK = ~REF_CLK;
   ord_core u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .UQ_VALID(UQ_VALID), .UQ_SLOT(UQ_SLOT), .UQ_READY(UQ_READY),
      .EXEC_FAULT(EXEC_FAULT), .EXEC_FAULT_TAG(EXEC_FAULT_TAG), .DISP(DISP), .ZERO_WR(ZERO_WR),
      .ZERO_REG(ZERO_REG), .RETIRE_CNT(RETIRE_CNT), .FAULT(FAULT), .FAULT_TAG(FAULT_TAG));
   ord_queue_model u_q (.REF_CLK(REF_CLK), .UQ_READY(UQ_READY), .UQ_VALID(UQ_VALID), .UQ_SLOT(UQ_SLOT));
   // Tally outputs; at the edge they still hold last cycle's settled values
   always @(posedge REF_CLK) begin
      for (int p = 0; p < 6; p++) if (DISP[p].v === 1'b1) begin
         ndisp++;
         ncls[DISP[p].cls]++;
         tag = DISP[p].tag;
      end
      for (int i = 0; i < 4; i++) if (ZERO_WR[i] === 1'b1) zmask[ZERO_REG[i]] = 1'b1;
   end
   function automatic ord_pkg::ord_slot_t mk(ord_pkg::ord_cls_t c, int a, int b, int d);
      return '{v: 1'b1, cls: c, dom: ord_pkg::D_INT, src1: 5'(a), src2: 5'(b), dst: 5'(d), use1: 1'b1,
         use2: 1'b1, wr: 1'b1, default: 1'b0};
   endfunction
   // Ops that leave at rename, and zero idioms that also write a zero
   function automatic logic gone(ord_pkg::ord_slot_t s);
      return s.cls inside {ord_pkg::C_NOP, ord_pkg::C_UPPER_VECTOR_ZEROING_OP, ord_pkg::C_FP_REGISTER_EXCHANGE};
   endfunction
   function automatic logic zid(ord_pkg::ord_slot_t s);
      return s.cls inside {ord_pkg::C_XOR_SUB, ord_pkg::C_PACKED_BITWISE_EXCLUSIVE_OR,
         ord_pkg::C_PACKED_INTEGER_SUBTRACT, ord_pkg::C_PACKED_FLOAT_EXCLUSIVE_OR} && s.src1 == s.src2;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Offer a group, then wait a bounded time for its units and zero writes
   task automatic run(input string name, input ord_grp_t g);
      int want, n;
      logic [31:0] zx;
      want = ndisp;
      zx = 32'h0;
      n = 0;
      foreach (g[i]) if (g[i].v) begin
         if (zid(g[i])) zx[g[i].dst] = 1'b1;
         else if (!gone(g[i])) want += g[i].idx ? 2 : 1;
      end
      zmask = 32'h0;
      u_q.offer(g);
      while ((ndisp < want || zmask != zx) && n++ < 100) #40;
      check({name, " units"}, ndisp, want);
      check({name, " zeros"}, zmask, zx);
      $display("%s finished", name);
   endtask
   // Directed corners, then random groups; slot 0, the oldest, is written last
   initial begin
      ord_grp_t g;
      int b;
      void'($urandom(32'ha02c));
      repeat (8) @(posedge REF_CLK);
      #1 RESET = 1'b0;
      g = '{mk(ord_pkg::C_SHIFT, 7, 7, 8), mk(ord_pkg::C_ALU, 3, 6, 7), mk(ord_pkg::C_ALU, 4, 5, 6),
         mk(ord_pkg::C_ALU, 1, 2, 3)};
      run("chain", g);
      g = '{mk(ord_pkg::C_XOR_SUB, 11, 11, 11), mk(ord_pkg::C_PACKED_FLOAT_EXCLUSIVE_OR, 9, 9, 10),
         mk(ord_pkg::C_UPPER_VECTOR_ZEROING_OP, 0, 0, 0), mk(ord_pkg::C_FP_REGISTER_EXCHANGE, 1, 2, 1)};
      run("zero", g);
      b = ncls[ord_pkg::C_BRANCH];
      g = '{mk(ord_pkg::C_BRANCH, 0, 0, 0), mk(ord_pkg::C_BRANCH, 1, 1, 0), mk(ord_pkg::C_BRANCH, 2, 2, 0),
         mk(ord_pkg::C_ALU, 1, 1, 2)};
      run("branch", g);
      check("branches", ncls[ord_pkg::C_BRANCH] - b, 3);
      b = ncls[ord_pkg::C_STD];
      g = '{mk(ord_pkg::C_ALU, 4, 4, 5), mk(ord_pkg::C_ALU, 1, 3, 9), mk(ord_pkg::C_STA, 1, 2, 0),
         mk(ord_pkg::C_ALU, 1, 2, 4)};
      g[0].idx = 1'b1;
      g[0].ld = 1'b1;
      g[1].idx = 1'b1;
      g[1].st = 1'b1;
      run("indexed", g);
      check("split store", ncls[ord_pkg::C_STD] - b, 1);
      b = ncls[ord_pkg::C_PACKED_EQUAL_COMPARE];
      g = '{mk(ord_pkg::C_VF_CVT, 3, 4, 6), mk(ord_pkg::C_PACKED_INTEGER_SUBTRACT, 5, 5, 14),
         mk(ord_pkg::C_PACKED_EQUAL_COMPARE, 20, 20, 13), mk(ord_pkg::C_VF_DIV, 1, 2, 20)};
      run("ones", g);
      check("ones compare", ncls[ord_pkg::C_PACKED_EQUAL_COMPARE] - b, 1);
      for (int k = 0; k < 24; k++) begin
         foreach (g[i]) begin
            g[i] = mk(ord_pkg::ord_cls_t'(($urandom % 2) ? 3 + $urandom % 7 : 13 + $urandom % 17),
               $urandom % 32, $urandom % 32, $urandom % 32);
            g[i].dom = ord_pkg::ord_dom_t'($urandom % 4);
         end
         run("random", g);
      end
      g = '0;
      g[0] = mk(ord_pkg::C_VF_DIV, 1, 2, 3);
      run("fault", g);
      EXEC_FAULT = 1'b1;
      EXEC_FAULT_TAG = tag;
      #40 EXEC_FAULT = 1'b0;
      b = 0;
      while (FAULT !== 1'b1 && b++ < 40) #40;
      check("fault", FAULT, 1'b1);
      check("fault tag", FAULT_TAG, tag);
      $display("flush finished");
      tally_and_finish();
   end
   // About 30 groups of at most 300 cycles each, with margin
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
endmodule

// ===== bench/ord_core_monitor.sv
// Purpose: Port checks of the rename/dispatch core
// Assumes: One clock; RESET synchronous, active high
// Notes: Class-to-port checks look at DISP only
module ord_core_monitor (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic UQ_VALID,
   input wire logic UQ_READY,
   input wire ord_pkg::ord_disp_t [ord_pkg::NUM_PORTS-1:0] DISP,
   input wire logic [2:0] RETIRE_CNT,
   input wire logic FAULT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] br, sd, ma, nm, id;
   // Which ports carry which classes this cycle
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         br[p] = DISP[p].v && DISP[p].cls == ord_pkg::C_BRANCH;
         sd[p] = DISP[p].v && DISP[p].cls == ord_pkg::C_STD;
         ma[p] = DISP[p].v && DISP[p].cls inside {ord_pkg::C_LOAD, ord_pkg::C_STA};
         nm[p] = DISP[p].v && !(DISP[p].cls inside {ord_pkg::C_LOAD, ord_pkg::C_STA, ord_pkg::C_STD});
         id[p] = DISP[p].v && DISP[p].cls inside {ord_pkg::C_NOP, ord_pkg::C_UPPER_VECTOR_ZEROING_OP,
            ord_pkg::C_FP_REGISTER_EXCHANGE};
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   take_drops_ready_a: assert property (UQ_VALID && UQ_READY |=> !UQ_READY)
      else $error("ready held after take");
   branch_port_a: assert property (br[4:0] == 5'h00)
      else $error("branch off port 5");
   store_data_a: assert property ({sd[5], sd[3:0]} == 5'h00)
      else $error("store data off port 4");
   mem_addr_a: assert property ({ma[5:4], ma[1:0]} == 4'h0)
      else $error("address op off ports 2 and 3");
   mem_port_a: assert property (nm[4:2] == 3'h0)
      else $error("compute op on a memory port");
   idiom_nodisp_a: assert property (id == 6'h00)
      else $error("rename-only op dispatched");
   retire_max_a: assert property (RETIRE_CNT <= 3'h4)
      else $error("more than four retired");
   fault_pulse_a: assert property (FAULT |-> !UQ_READY ##1 (!FAULT && UQ_READY))
      else $error("flush timing wrong");
endmodule
bind ord_core ord_core_monitor u_mon (.REF_CLK(REF_CLK), .RESET(RESET), .UQ_VALID(UQ_VALID),
   .UQ_READY(UQ_READY), .DISP(DISP), .RETIRE_CNT(RETIRE_CNT), .FAULT(FAULT));

// ===== bench/ord_queue_model.sv
// Purpose: Micro-op queue model feeding rename groups
// Assumes: A group is taken on a rising edge with UQ_READY high
// Notes: Released slots show inverted data, never the old group
module ord_queue_model (
   input wire logic REF_CLK,
   input wire logic UQ_READY,
   output logic UQ_VALID,
   output ord_pkg::ord_slot_t [ord_pkg::REN_W-1:0] UQ_SLOT
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      UQ_VALID = 1'b0;
      UQ_SLOT = '0;
   end
   // Hold the whole group until the take edge; bounded so a hang cannot stall here
   task automatic offer(input ord_pkg::ord_slot_t [ord_pkg::REN_W-1:0] g);
      int n;
      n = 0;
      UQ_VALID = 1'b1;
      UQ_SLOT = g;
      do @(posedge REF_CLK); while (UQ_READY !== 1'b1 && n++ < 200);
      #1 UQ_VALID = 1'b0;
      UQ_SLOT = ~g;
   endtask
endmodule

// ===== verilog/ord_core.sv
// Purpose: Rename, scheduling, dispatch and in-order retirement of micro-ops
// Assumes: Queue and execution units run on REF_CLK; ROB_N is a power of two
// Notes:   The reorder buffer doubles as scheduler; its index is the physical tag
module ord_core #(
   parameter int ROB_N = 16,
   parameter int LB_N = 64,
   parameter int SB_N = 36
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic UQ_VALID,
   input wire ord_pkg::ord_slot_t [ord_pkg::REN_W-1:0] UQ_SLOT,
   output logic UQ_READY,
   input wire logic EXEC_FAULT,
   input wire logic [ord_pkg::TAG_W-1:0] EXEC_FAULT_TAG,
   output ord_pkg::ord_disp_t [ord_pkg::NUM_PORTS-1:0] DISP,
   output logic [ord_pkg::REN_W-1:0] ZERO_WR,
   output logic [ord_pkg::REN_W-1:0][4:0] ZERO_REG,
   output logic [2:0] RETIRE_CNT,
   output logic FAULT,
   output logic [ord_pkg::TAG_W-1:0] FAULT_TAG
);
   localparam int IW = $clog2(ROB_N);
   localparam int NR = ord_pkg::NUM_ARCH;
   localparam int NP = ord_pkg::NUM_PORTS;
   localparam int RW = ord_pkg::REN_W;
   localparam int TW = ord_pkg::TAG_W;
   localparam int CW = 8;

   ord_pkg::ord_rob_t rob [ROB_N];
   ord_pkg::ord_rob_t next_rob [ROB_N];
   ord_pkg::ord_rob_t new_e [RW];
   logic [IW-1:0] head, tail;
   logic [IW:0] cnt;
   logic [TW-1:0] map_tag [NR];
   logic [TW-1:0] next_map_tag [NR];
   logic [NR-1:0] map_pend, next_map_pend;
   ord_pkg::ord_slot_t [RW-1:0] stage, next_stage;
   logic [CW-1:0] ld_cnt, st_cnt;
   logic [ord_pkg::MAX_LAT:0] resv [NP][ord_pkg::NUM_STACKS];
   logic [ord_pkg::MAX_LAT:0] next_resv [NP][ord_pkg::NUM_STACKS];
   logic [RW-1:0] take, zmask;
   logic [RW-1:0][4:0] zreg;
   int n_new, nl, ns, rc, rl, rs;
   logic flush;
   logic [ROB_N-1:0] rdy, xf;
   logic [1:0] bypv [ROB_N];
   logic sel_v [NP];
   logic [IW-1:0] sel_i [NP];
   ord_pkg::ord_disp_t [NP-1:0] next_disp;
   wire capture = UQ_VALID && UQ_READY;
   wire [IW:0] free_ents = (IW + 1)'(ROB_N) - cnt;

   function automatic logic [TW-1:0] tag_of(int i);
      return TW'(IW'(i));
   endfunction

   // Fresh entry for one renamed micro-op, bound to its port
   function automatic ord_pkg::ord_rob_t mk(ord_pkg::ord_cls_t c, ord_pkg::ord_dom_t d, logic [TW-1:0] tg);
      ord_pkg::ord_rob_t e;
      e = '0;
      e.v = 1'b1;
      e.cls = c;
      e.dom = d;
      e.port = ord_pkg::bind_port(c, tg[0]);
      e.done = (e.port == ord_pkg::P_NONE);
      e.disp = e.done;
      return e;
   endfunction

   // Retirement walk: oldest first, stops at first unfinished or faulting entry
   always_comb begin
      logic stop;
      ord_pkg::ord_rob_t e;
      stop = 1'b0;
      e = '0;
      rc = 0;
      rl = 0;
      rs = 0;
      flush = 1'b0;
      for (int i = 0; i < ord_pkg::RET_W; i++) begin
         e = rob[IW'(int'(head) + i)];
         if (stop || i >= int'(cnt) || !e.done) begin
            stop = 1'b1;
         end else if (e.flt) begin
            flush = (i == 0);
            stop = 1'b1;
         end else begin
            rc = rc + 1;
            rl = rl + int'(e.ld);
            rs = rs + int'(e.st);
         end
      end
   end

   // Rename group: in-order prefix limited by slots, branches, entries, buffers
   always_comb begin
      int used;
      int br;
      int need;
      logic stop;
      logic [TW-1:0] tg;
      logic [TW-1:0] tsw;
      logic psw;
      logic zi;
      ord_pkg::ord_slot_t s;
      ord_pkg::ord_rob_t e;
      used = 0;
      br = 0;
      need = 0;
      stop = 1'b0;
      tg = '0;
      tsw = '0;
      psw = 1'b0;
      zi = 1'b0;
      s = '0;
      e = '0;
      n_new = 0;
      nl = 0;
      ns = 0;
      take = '0;
      zmask = '0;
      zreg = '0;
      for (int j = 0; j < RW; j++) new_e[j] = '0;
      next_map_tag = map_tag;
      next_map_pend = map_pend;
      // Retiring producers hand their register back to the file
      for (int r = 0; r < ord_pkg::RET_W; r++) begin
         e = rob[IW'(int'(head) + r)];
         if (r < rc && e.wr && next_map_tag[e.dst] == tag_of(int'(head) + r))
            next_map_pend[e.dst] = 1'b0;
      end
      for (int i = 0; i < RW; i++) begin
         s = stage[i];
         need = s.idx ? 2 : 1;
         if (s.v && !stop) begin
            if (used + need > RW || n_new + need > int'(free_ents)
                || br + int'(s.cls == ord_pkg::C_BRANCH) > ord_pkg::BR_MAX
                || int'(ld_cnt) + nl + int'(s.ld) > LB_N || int'(st_cnt) + ns + int'(s.st) > SB_N) begin
               stop = 1'b1;
            end else begin
               take[i] = 1'b1;
               used = used + need;
               br = br + int'(s.cls == ord_pkg::C_BRANCH);
               nl = nl + int'(s.ld);
               ns = ns + int'(s.st);
               zi = s.use1 && s.use2 && s.src1 == s.src2;
               if (s.idx) begin
                  // Address half first; the operation or data half follows
                  tg = tag_of(int'(tail) + n_new);
                  e = mk(s.st ? ord_pkg::C_STA : ord_pkg::C_LOAD, ord_pkg::D_INT, tg);
                  e.ld = s.ld;
                  e.st = s.st;
                  e.t1 = next_map_tag[s.src1];
                  e.p1 = s.use1 && next_map_pend[s.src1];
                  new_e[n_new] = e;
                  n_new = n_new + 1;
                  tsw = tg;
                  tg = tag_of(int'(tail) + n_new);
                  e = mk(s.st ? ord_pkg::C_STD : s.cls, s.dom, tg);
                  e.t1 = next_map_tag[s.src2];
                  e.p1 = s.use2 && next_map_pend[s.src2];
                  e.t2 = tsw;
                  e.p2 = !s.st;
               end else begin
                  tg = tag_of(int'(tail) + n_new);
                  e = mk(s.cls, s.dom, tg);
                  e.ld = s.ld;
                  e.st = s.st;
                  e.t1 = next_map_tag[s.src1];
                  e.t2 = next_map_tag[s.src2];
                  e.p1 = s.use1 && next_map_pend[s.src1];
                  e.p2 = s.use2 && next_map_pend[s.src2];
                  if (zi && (s.cls == ord_pkg::C_XOR_SUB || s.cls == ord_pkg::C_PACKED_BITWISE_EXCLUSIVE_OR
                      || s.cls == ord_pkg::C_PACKED_INTEGER_SUBTRACT
                      || s.cls == ord_pkg::C_PACKED_FLOAT_EXCLUSIVE_OR)) begin
                     e.port = ord_pkg::P_NONE;
                     e.done = 1'b1;
                     e.disp = 1'b1;
                     e.p1 = 1'b0;
                     e.p2 = 1'b0;
                     zmask[i] = s.wr;
                     zreg[i] = s.dst;
                  end
                  if (zi && s.cls == ord_pkg::C_PACKED_EQUAL_COMPARE) begin
                     e.p1 = 1'b0;
                     e.p2 = 1'b0;
                  end
               end
               // Destination mapping; the exchange only swaps two map entries
               if (s.cls == ord_pkg::C_FP_REGISTER_EXCHANGE) begin
                  tsw = next_map_tag[s.dst];
                  psw = next_map_pend[s.dst];
                  next_map_tag[s.dst] = next_map_tag[s.src1];
                  next_map_pend[s.dst] = next_map_pend[s.src1];
                  next_map_tag[s.src1] = tsw;
                  next_map_pend[s.src1] = psw;
               end else if (s.wr && zmask[i]) begin
                  next_map_pend[s.dst] = 1'b0;
               end else if (s.wr) begin
                  e.wr = 1'b1;
                  e.dst = s.dst;
                  next_map_tag[s.dst] = tg;
                  next_map_pend[s.dst] = 1'b1;
               end
               new_e[n_new] = e;
               n_new = n_new + 1;
            end
         end
      end
   end

   // Operand readiness with the cross-domain forwarding delay
   always_comb begin
      ord_pkg::ord_rob_t e;
      ord_pkg::ord_rob_t a;
      ord_pkg::ord_rob_t b;
      logic ok1;
      logic ok2;
      logic wbok;
      e = '0;
      a = '0;
      b = '0;
      ok1 = 1'b0;
      ok2 = 1'b0;
      wbok = 1'b0;
      for (int k = 0; k < ROB_N; k++) begin
         e = rob[k];
         a = rob[e.t1[IW-1:0]];
         b = rob[e.t2[IW-1:0]];
         ok1 = !e.p1 || (a.done && a.age >= ord_pkg::byp_dly(a.dom, a.cls == ord_pkg::C_LOAD, e.dom));
         ok2 = !e.p2 || (b.done && b.age >= ord_pkg::byp_dly(b.dom, b.cls == ord_pkg::C_LOAD, e.dom));
         wbok = (e.cls == ord_pkg::C_STA || e.cls == ord_pkg::C_STD) || e.port >= 3'(NP)
                || !resv[e.port][ord_pkg::wb_stack(e.dom)][ord_pkg::lat(e.cls)];
         rdy[k] = e.v && !e.disp && ok1 && ok2 && wbok;
         bypv[k] = {e.p2 && b.age < ord_pkg::BYP_AGE, e.p1 && a.age < ord_pkg::BYP_AGE};
         xf[k] = (e.p1 && ord_pkg::needs_xfer(a.dom, a.cls == ord_pkg::C_LOAD, e.dom))
                 || (e.p2 && ord_pkg::needs_xfer(b.dom, b.cls == ord_pkg::C_LOAD, e.dom));
      end
   end

   // Per port: oldest ready entry bound to that port
   always_comb begin
      logic [IW-1:0] idx;
      idx = '0;
      for (int p = 0; p < NP; p++) begin
         sel_v[p] = 1'b0;
         sel_i[p] = '0;
         for (int k = 0; k < ROB_N; k++) begin
            idx = IW'(int'(head) + k);
            if (!sel_v[p] && rdy[idx] && rob[idx].port == 3'(p)) begin
               sel_v[p] = 1'b1;
               sel_i[p] = idx;
            end
         end
         next_disp[p].v = sel_v[p] && !flush;
         next_disp[p].tag = TW'(sel_i[p]);
         next_disp[p].cls = rob[sel_i[p]].cls;
         next_disp[p].byp = bypv[sel_i[p]];
         next_disp[p].xfer = xf[sel_i[p]];
      end
   end

   // Writeback bus slots per port and stack; bit n is busy n cycles ahead
   always_comb begin
      ord_pkg::ord_rob_t e;
      e = '0;
      for (int p = 0; p < NP; p++) begin
         for (int s = 0; s < ord_pkg::NUM_STACKS; s++) next_resv[p][s] = resv[p][s] >> 1;
         e = rob[sel_i[p]];
         if (sel_v[p] && e.cls != ord_pkg::C_STA && e.cls != ord_pkg::C_STD)
            next_resv[p][ord_pkg::wb_stack(e.dom)][ord_pkg::lat(e.cls) - 4'h1] = 1'b1;
      end
   end

   // Entry state: completion timers, dispatch marks, faults, retire, allocate
   always_comb begin
      logic [TW-1:0] rt;
      rt = '0;
      next_rob = rob;
      for (int k = 0; k < ROB_N; k++) begin
         if (rob[k].v && rob[k].done && rob[k].age != ord_pkg::AGE_SAT)
            next_rob[k].age = rob[k].age + 2'h1;
         else if (rob[k].v && rob[k].disp && !rob[k].done) begin
            next_rob[k].done = rob[k].timer <= 4'h1;
            next_rob[k].timer = rob[k].timer - 4'h1;
         end
      end
      for (int p = 0; p < NP; p++) begin
         if (sel_v[p]) begin
            next_rob[sel_i[p]].disp = 1'b1;
            next_rob[sel_i[p]].done = ord_pkg::lat(rob[sel_i[p]].cls) == ord_pkg::L_ONE;
            next_rob[sel_i[p]].timer = ord_pkg::lat(rob[sel_i[p]].cls) - 4'h1;
         end
      end
      if (EXEC_FAULT && rob[EXEC_FAULT_TAG[IW-1:0]].v)
         next_rob[EXEC_FAULT_TAG[IW-1:0]].flt = 1'b1;
      for (int r = 0; r < ord_pkg::RET_W; r++) begin
         if (r < rc) begin
            rt = tag_of(int'(head) + r);
            next_rob[rt[IW-1:0]].v = 1'b0;
            for (int k = 0; k < ROB_N; k++) begin
               if (rob[k].t1 == rt) next_rob[k].p1 = 1'b0;
               if (rob[k].t2 == rt) next_rob[k].p2 = 1'b0;
            end
         end
      end
      for (int j = 0; j < RW; j++) if (j < n_new) next_rob[IW'(int'(tail) + j)] = new_e[j];
      if (flush) for (int k = 0; k < ROB_N; k++) next_rob[k].v = 1'b0;
   end

   // Rename stage register: taken slots drop out, a new group only when empty
   always_comb begin
      next_stage = stage;
      for (int i = 0; i < RW; i++) if (take[i]) next_stage[i].v = 1'b0;
      if (capture) next_stage = UQ_SLOT;
      if (flush) next_stage = '0;
   end

   // Pointers, counts and outputs
   always_ff @(posedge REF_CLK) begin
      if (RESET || flush) begin
         head <= '0;
         tail <= '0;
         cnt <= '0;
         ld_cnt <= '0;
         st_cnt <= '0;
         map_pend <= '0;
      end else begin
         head <= IW'(int'(head) + rc);
         tail <= IW'(int'(tail) + n_new);
         cnt <= (IW + 1)'(int'(cnt) + n_new - rc);
         ld_cnt <= CW'(int'(ld_cnt) + nl - rl);
         st_cnt <= CW'(int'(st_cnt) + ns - rs);
         map_pend <= next_map_pend;
      end
   end

   always_ff @(posedge REF_CLK) begin
      map_tag <= next_map_tag;
      for (int k = 0; k < ROB_N; k++) rob[k] <= RESET ? '0 : next_rob[k];
      for (int p = 0; p < NP; p++)
         for (int s = 0; s < ord_pkg::NUM_STACKS; s++) resv[p][s] <= RESET ? '0 : next_resv[p][s];
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         stage <= '0;
         UQ_READY <= 1'b0;
         DISP <= '0;
         ZERO_WR <= '0;
         ZERO_REG <= '0;
         RETIRE_CNT <= '0;
         FAULT <= 1'b0;
         FAULT_TAG <= '0;
      end else begin
         stage <= next_stage;
         UQ_READY <= !capture && !flush && !(|{next_stage[3].v, next_stage[2].v, next_stage[1].v, next_stage[0].v});
         DISP <= next_disp;
         ZERO_WR <= flush ? '0 : zmask;
         ZERO_REG <= zreg;
         RETIRE_CNT <= 3'(rc);
         FAULT <= flush;
         FAULT_TAG <= TW'(head);
      end
   end
endmodule

// ===== verilog/ord_pkg.sv
// Purpose: Shared types, constants and helpers of the rename/dispatch core
// Assumes: One core clock, synchronous active-high reset
// Notes:   Port masks use bit n for dispatch port n
package ord_pkg;
   localparam int NUM_PORTS = 6;
   localparam int REN_W = 4;
   localparam int BR_MAX = 2;
   localparam int RET_W = 4;
   localparam int NUM_ARCH = 32;
   localparam int TAG_W = 8;
   localparam int MAX_LAT = 15;
   localparam int NUM_STACKS = 3;
   localparam logic [1:0] BYP_AGE = 2'h2; // Older results are read from the file
   localparam logic [1:0] AGE_SAT = 2'h3;
   localparam logic [2:0] P_NONE = 3'h7;
   localparam logic [5:0] M_P0 = 6'h01;
   localparam logic [5:0] M_P1 = 6'h02;
   localparam logic [5:0] M_P2 = 6'h04;
   localparam logic [5:0] M_P3 = 6'h08;
   localparam logic [5:0] M_P4 = 6'h10;
   localparam logic [5:0] M_P5 = 6'h20;
   localparam logic [3:0] L_ONE = 4'h1;
   localparam logic [3:0] L_MUL = 4'h3;
   localparam logic [3:0] L_FADD = 4'h3;
   localparam logic [3:0] L_FMUL = 4'h5;
   localparam logic [3:0] L_LOAD = 4'h4;
   localparam logic [3:0] L_DIV = 4'he;
   localparam logic [1:0] B_NONE = 2'h0;
   localparam logic [1:0] B_ONE = 2'h1;
   localparam logic [1:0] B_TWO = 2'h2;
   localparam logic [1:0] WB_INT = 2'h0;
   localparam logic [1:0] WB_VEC = 2'h1;
   localparam logic [1:0] WB_HI = 2'h2;

   typedef enum logic [4:0] {
      C_NOP, C_UPPER_VECTOR_ZEROING_OP, C_FP_REGISTER_EXCHANGE, C_XOR_SUB, C_ALU, C_SHIFT,
      C_BRANCH, C_ADDRESS_CALC_OP_FAST, C_ADDRESS_CALC_OP_SLOW, C_IMUL, C_LOAD, C_STA, C_STD,
      C_VI_MUL, C_VI_SHIFT, C_STRING_TEXT_COMPARE, C_VI_DIV, C_VI_ALU, C_VI_SHUF, C_VI_BLEND,
      C_PACKED_BITWISE_EXCLUSIVE_OR, C_PACKED_INTEGER_SUBTRACT, C_PACKED_FLOAT_EXCLUSIVE_OR,
      C_PACKED_EQUAL_COMPARE, C_VF_MUL, C_VF_DIV, C_VF_BLEND, C_VF_ADD, C_VF_CVT, C_VF_SHUF
   } ord_cls_t;

   // Execution domain: integer, vector integer, low-half float, legacy/high-half float
   typedef enum logic [1:0] {D_INT, D_VINT, D_VFLO, D_VFHI} ord_dom_t;

   typedef struct packed {
      logic v;
      ord_cls_t cls;
      ord_dom_t dom;
      logic [4:0] src1;
      logic [4:0] src2;
      logic [4:0] dst;
      logic use1;
      logic use2;
      logic wr;
      logic ld;
      logic st;
      logic idx;
   } ord_slot_t;

   typedef struct packed {
      logic v;
      logic [TAG_W-1:0] tag;
      ord_cls_t cls;
      logic [1:0] byp;
      logic xfer;
   } ord_disp_t;

   typedef struct packed {
      logic v;
      ord_cls_t cls;
      ord_dom_t dom;
      logic [2:0] port;
      logic ld;
      logic st;
      logic wr;
      logic [4:0] dst;
      logic [TAG_W-1:0] t1;
      logic [TAG_W-1:0] t2;
      logic p1;
      logic p2;
      logic disp;
      logic done;
      logic [1:0] age;
      logic [3:0] timer;
      logic flt;
   } ord_rob_t;

   // Candidate dispatch ports per class
   function automatic logic [5:0] port_mask(ord_cls_t c);
      case (c)
         C_ALU, C_XOR_SUB: return M_P0 | M_P1 | M_P5;
         C_SHIFT: return M_P0 | M_P5;
         C_BRANCH: return M_P5;
         C_ADDRESS_CALC_OP_FAST: return M_P1 | M_P5;
         C_ADDRESS_CALC_OP_SLOW, C_IMUL: return M_P1;
         C_LOAD, C_STA: return M_P2 | M_P3;
         C_STD: return M_P4;
         C_VI_MUL, C_STRING_TEXT_COMPARE, C_VI_DIV: return M_P0;
         C_VI_SHIFT: return M_P0 | M_P5;
         C_VI_ALU, C_VI_SHUF, C_VI_BLEND, C_PACKED_BITWISE_EXCLUSIVE_OR: return M_P1 | M_P5;
         C_PACKED_INTEGER_SUBTRACT, C_PACKED_EQUAL_COMPARE: return M_P1 | M_P5;
         C_VF_MUL, C_VF_DIV: return M_P0;
         C_VF_BLEND: return M_P0 | M_P5;
         C_VF_ADD, C_VF_CVT: return M_P1;
         C_VF_SHUF, C_PACKED_FLOAT_EXCLUSIVE_OR: return M_P5;
         default: return '0;
      endcase
   endfunction

   function automatic logic [3:0] lat(ord_cls_t c);
      case (c)
         C_IMUL, C_VI_MUL, C_STRING_TEXT_COMPARE: return L_MUL;
         C_VF_MUL: return L_FMUL;
         C_VF_ADD, C_VF_CVT: return L_FADD;
         C_VI_DIV, C_VF_DIV: return L_DIV;
         C_LOAD: return L_LOAD;
         default: return L_ONE;
      endcase
   endfunction

   // Lowest or highest candidate port; spreads two-port classes by tag parity
   function automatic logic [2:0] bind_port(ord_cls_t c, logic alt);
      logic [5:0] m;
      logic [2:0] lo;
      logic [2:0] hi;
      m = port_mask(c);
      lo = P_NONE;
      hi = P_NONE;
      for (int i = NUM_PORTS - 1; i >= 0; i--) if (m[i]) lo = 3'(i);
      for (int i = 0; i < NUM_PORTS; i++) if (m[i]) hi = 3'(i);
      return alt ? hi : lo;
   endfunction

   function automatic logic [1:0] wb_stack(ord_dom_t d);
      case (d)
         D_INT: return WB_INT;
         D_VFHI: return WB_HI;
         default: return WB_VEC;
      endcase
   endfunction

   // Extra cycles from producer domain to consumer domain
   function automatic logic [1:0] byp_dly(ord_dom_t p, logic ld, ord_dom_t c);
      if (ld) return (c == D_INT) ? B_NONE : (c == D_VFHI) ? B_TWO : B_ONE;
      if (p == c) return B_NONE;
      case (p)
         D_INT: return (c == D_VFHI) ? B_TWO : B_ONE;
         D_VINT: return (c == D_VFHI) ? B_NONE : B_ONE;
         D_VFLO: return (c == D_VFHI) ? B_TWO : B_ONE;
         default: return (c == D_VINT) ? B_NONE : B_TWO;
      endcase
   endfunction

   // Transition micro-op needed on the crossing
   function automatic logic needs_xfer(ord_dom_t p, logic ld, ord_dom_t c);
      if (ld || p == c) return 1'b0;
      return p == D_INT || c == D_INT || (p == D_VFLO && c == D_VFHI) || (p == D_VFHI && c == D_VFLO);
   endfunction
endpackage
